// ==== bee_consts.svh ====
`ifndef BEE_CONSTS_SVH
`define BEE_CONSTS_SVH

// ==========================================
// Register indices on the CPU I/O port
`define BEE_REG_CTRL 2'h0
`define BEE_REG_VALUE 2'h1
`define BEE_REG_PTR_LO 2'h2
`define BEE_REG_PTR_HI 2'h3

// ==========================================
// Control register bit positions
`define BEE_CTL_READ 0
`define BEE_CTL_WRITE 1
`define BEE_CTL_ARM 2
`define BEE_CTL_IRQ_EN 3
`define BEE_CTL_ACT_LO 4
`define BEE_CTL_ACT_HI 5

// ==========================================
// Array geometry
`define BEE_NVM_BYTES 320
`define BEE_NVM_LAST 9'h13F
`define BEE_LOWER_LAST 9'h0FF
`define BEE_ERASED_BYTE 8'hFF

// ==========================================
// Cycle counts on sys_clk
`define BEE_ARM_CYCLES 3'h4
`define BEE_RD_STALL 3'h4
`define BEE_WR_STALL 3'h2

// ==========================================
// Programming times in calibrated RC oscillator cycles and in microseconds
`define BEE_TICKS_ERASE_WRITE 67584
`define BEE_TIME_EW_US 3400
`define BEE_TIME_HALF_US 1800
`define BEE_TICKS_HALF ((`BEE_TICKS_ERASE_WRITE * `BEE_TIME_HALF_US + `BEE_TIME_EW_US - 1) / `BEE_TIME_EW_US)
`define BEE_TICK_W 17

`endif

// ==== bee_pkg.sv ====
`default_nettype none

package bee_pkg;

   // Program action field, encoded in declaration order
   typedef enum logic [1:0] {
      BEE_ACT_ERASE_WRITE,
      BEE_ACT_ERASE_ONLY,
      BEE_ACT_WRITE_ONLY,
      BEE_ACT_RESERVED
   } bee_action_t;

   typedef enum logic {
      BEE_ENG_IDLE,
      BEE_ENG_PROG
   } bee_eng_st_t;

   typedef struct packed {
      logic [2:0] arm_cnt;
      logic [2:0] stall_cnt;
      logic stall;
      logic irq_en;
      logic irq;
      logic [8:0] ptr;
      logic [7:0] value;
      logic [7:0] rdata;
   } bee_ctl_state_t;

   typedef struct packed {
      bee_eng_st_t st;
      bee_action_t action;
      logic [16:0] ticks;
      logic [8:0] addr;
      logic [7:0] data;
      logic done;
   } bee_eng_state_t;

endpackage

`default_nettype wire

// ==== bee_prog_engine.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "bee_consts.svh"

module bee_prog_engine #(
   parameter int unsigned EW_TICKS = `BEE_TICKS_ERASE_WRITE,
   parameter int unsigned HALF_TICKS = `BEE_TICKS_HALF
) (
   // Clock and resets
   input wire logic sys_clk,
   input wire logic por_n,
   input wire logic rst_n,
   // Oscillator timing
   input wire logic rc_osc_tick,
   // Requests from the register side
   input wire logic start,
   input wire logic act_wr,
   input wire logic [1:0] act_wdata,
   input wire logic [8:0] addr_in,
   input wire logic [7:0] data_in,
   // Status and completion
   output logic busy,
   output logic [1:0] action,
   output logic done,
   output logic [8:0] done_addr,
   output logic [7:0] done_data
);

   bee_pkg::bee_eng_state_t s_r, s_nxt;
   bee_pkg::bee_action_t act_eff;
   logic rst_seen_r;

   // ==========================================
   // CPU reset seen
   // Engine survives CPU reset so a running write finishes
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_seen_r <= 1'b1;
      end else begin
         rst_seen_r <= 1'b0;
      end
   end

   // ==========================================
   // Next state
   always_comb begin
      s_nxt = s_r;
      s_nxt.done = 1'b0;
      act_eff = act_wr ? bee_pkg::bee_action_t'(act_wdata) : s_r.action;
      unique case (s_r.st)
         bee_pkg::BEE_ENG_IDLE: begin
            if (act_wr) begin
               s_nxt.action = act_eff;
            end
            if (rst_seen_r) begin
               s_nxt.action = bee_pkg::BEE_ACT_ERASE_WRITE;
            end
            if (start) begin
               s_nxt.st = bee_pkg::BEE_ENG_PROG;
               s_nxt.action = act_eff;
               s_nxt.addr = addr_in;
               s_nxt.data = data_in;
               s_nxt.ticks = (act_eff == bee_pkg::BEE_ACT_ERASE_WRITE) ?
                  EW_TICKS[16:0] : HALF_TICKS[16:0];
            end
         end
         bee_pkg::BEE_ENG_PROG: begin
            if (rc_osc_tick) begin
               s_nxt.ticks = s_r.ticks - 17'h00001;
               if (s_r.ticks == 17'h00001) begin
                  s_nxt.st = bee_pkg::BEE_ENG_IDLE;
                  s_nxt.done = 1'b1;
               end
            end
         end
      endcase
   end

   always_ff @(posedge sys_clk or negedge por_n) begin
      if (!por_n) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign busy = (s_r.st == bee_pkg::BEE_ENG_PROG);
   assign action = s_r.action;
   assign done = s_r.done;
   assign done_addr = s_r.addr;
   assign done_data = s_r.data;

   // ==========================================
   // Checks
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!por_n);

   AST_BUSY_ENDS_DONE: assert property ($fell(busy) |-> done)
      else $error("busy fell without completion pulse");
   AST_ACT_RESET: assert property (rst_seen_r && !busy && !start |=> action == 2'h0)
      else $error("action not cleared by reset while idle");

endmodule // bee_prog_engine

`default_nettype wire

// ==== bee_access_ctrl.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "bee_consts.svh"

module bee_access_ctrl #(
   parameter int unsigned EW_TICKS = `BEE_TICKS_ERASE_WRITE,
   parameter int unsigned HALF_TICKS = `BEE_TICKS_HALF
) (
   // Clock and resets
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic por_n,
   // CPU register port
   input wire logic [1:0] io_addr,
   input wire logic io_wr,
   input wire logic io_rd,
   input wire logic [7:0] io_wdata,
   output logic [7:0] io_rdata,
   // CPU control
   output logic cpu_stall,
   input wire logic cpu_global_irq_en,
   output logic ready_irq,
   // Device environment
   input wire logic upper_area_lock_fuse,
   input wire logic flash_selfprog_active,
   input wire logic rc_osc_tick
);

   bee_pkg::bee_ctl_state_t s_r, s_nxt;
   logic [7:0] nvm_array [`BEE_NVM_BYTES];
   logic busy;
   logic [1:0] action;
   logic eng_done;
   logic [8:0] done_addr;
   logic [7:0] done_data;
   logic arm_act;
   logic ctl_wr;
   logic start;
   logic read_go;
   logic act_wr;
   logic upper_locked;
   logic [7:0] array_rd;
   logic [7:0] ctl_view;

   // ==========================================
   // Programming engine
   bee_prog_engine #(
      .EW_TICKS(EW_TICKS),
      .HALF_TICKS(HALF_TICKS)
   ) i_bee_prog_engine (
      .sys_clk(sys_clk),
      .por_n(por_n),
      .rst_n(rst_n),
      .rc_osc_tick(rc_osc_tick),
      .start(start),
      .act_wr(act_wr),
      .act_wdata(io_wdata[`BEE_CTL_ACT_HI:`BEE_CTL_ACT_LO]),
      .addr_in(s_r.ptr),
      .data_in(s_r.value),
      .busy(busy),
      .action(action),
      .done(eng_done),
      .done_addr(done_addr),
      .done_data(done_data)
   );

   // ==========================================
   // Request decode
   assign arm_act = (s_r.arm_cnt != 3'h0);
   assign ctl_wr = io_wr && (io_addr == `BEE_REG_CTRL);
   // engine drops action writes while busy
   assign act_wr = ctl_wr && !busy;
   assign upper_locked = upper_area_lock_fuse && (s_r.ptr > `BEE_LOWER_LAST);
   assign start = ctl_wr && io_wdata[`BEE_CTL_WRITE] && arm_act && !busy
      && !flash_selfprog_active && !upper_locked
      && (io_wdata[`BEE_CTL_ACT_HI:`BEE_CTL_ACT_LO] != 2'(bee_pkg::BEE_ACT_RESERVED));
   assign read_go = ctl_wr && io_wdata[`BEE_CTL_READ] && !busy;
   assign array_rd = (s_r.ptr <= `BEE_NVM_LAST) ? nvm_array[s_r.ptr] : `BEE_ERASED_BYTE;
   // read strobe always reads back zero
   assign ctl_view = {2'h0, action, s_r.irq_en, arm_act, busy, 1'b0};

   // ==========================================
   // Next state
   always_comb begin
      s_nxt = s_r;
      if (s_r.arm_cnt != 3'h0) begin
         s_nxt.arm_cnt = s_r.arm_cnt - 3'h1;
      end
      if (s_r.stall_cnt != 3'h0) begin
         s_nxt.stall_cnt = s_r.stall_cnt - 3'h1;
      end
      if (io_wr) begin
         unique case (io_addr)
            `BEE_REG_CTRL: begin
               s_nxt.irq_en = io_wdata[`BEE_CTL_IRQ_EN];
               // arm window, not extended by rewrite
               if (io_wdata[`BEE_CTL_ARM] && !io_wdata[`BEE_CTL_WRITE] && !arm_act) begin
                  s_nxt.arm_cnt = `BEE_ARM_CYCLES;
               end
               if (start) begin
                  s_nxt.arm_cnt = 3'h0;
                  s_nxt.stall_cnt = `BEE_WR_STALL;
               end
               // byte fetched in the strobe cycle
               if (read_go) begin
                  s_nxt.value = array_rd;
                  s_nxt.stall_cnt = `BEE_RD_STALL;
               end
            end
            `BEE_REG_VALUE: begin
               s_nxt.value = io_wdata;
            end
            `BEE_REG_PTR_LO: begin
               if (!busy) begin
                  s_nxt.ptr[7:0] = io_wdata;
               end
            end
            `BEE_REG_PTR_HI: begin
               if (!busy) begin
                  s_nxt.ptr[8] = io_wdata[0];
               end
            end
         endcase
      end
      s_nxt.stall = (s_nxt.stall_cnt != 3'h0);
      s_nxt.irq = s_nxt.irq_en && cpu_global_irq_en && !busy;
      if (io_rd) begin
         unique case (io_addr)
            `BEE_REG_CTRL: s_nxt.rdata = ctl_view;
            `BEE_REG_VALUE: s_nxt.rdata = s_r.value;
            `BEE_REG_PTR_LO: s_nxt.rdata = s_r.ptr[7:0];
            `BEE_REG_PTR_HI: s_nxt.rdata = {7'h00, s_r.ptr[8]};
         endcase
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   // ==========================================
   // Array update at end of programming
   // Write-only can only clear bits; erase sets all ones
   always_ff @(posedge sys_clk) begin
      if (eng_done && (done_addr <= `BEE_NVM_LAST)) begin
         unique case (bee_pkg::bee_action_t'(action))
            bee_pkg::BEE_ACT_ERASE_WRITE: nvm_array[done_addr] <= done_data;
            bee_pkg::BEE_ACT_ERASE_ONLY: nvm_array[done_addr] <= `BEE_ERASED_BYTE;
            bee_pkg::BEE_ACT_WRITE_ONLY: nvm_array[done_addr] <= nvm_array[done_addr] & done_data;
            bee_pkg::BEE_ACT_RESERVED: nvm_array[done_addr] <= nvm_array[done_addr];
         endcase
      end
   end

   assign io_rdata = s_r.rdata;
   assign cpu_stall = s_r.stall;
   assign ready_irq = s_r.irq;

   // ==========================================
   // Checks
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   AST_ARM_TIMEOUT: assert property ($rose(arm_act) |-> ##4 !arm_act)
      else $error("arm did not expire after four cycles");
   AST_ARM_SET: assert property (ctl_wr && io_wdata[`BEE_CTL_ARM] && !io_wdata[`BEE_CTL_WRITE] && !arm_act
      |=> arm_act)
      else $error("arm write did not arm");
   AST_ARM_NO_EXTEND: assert property (arm_act && ctl_wr && !io_wdata[`BEE_CTL_WRITE]
      |=> s_r.arm_cnt == $past(s_r.arm_cnt) - 3'h1)
      else $error("arm window extended by rewrite");
   AST_START_DISARMS: assert property (start |=> !arm_act)
      else $error("arm still set after start");
   AST_RD_STALL: assert property (read_go |=> cpu_stall [*4] ##1 !cpu_stall)
      else $error("read stall is not four cycles");
   AST_WR_STALL: assert property (start |=> cpu_stall [*2] ##1 !cpu_stall)
      else $error("write stall is not two cycles");
   AST_NO_IDLE_STALL: assert property (!cpu_stall && !read_go && !start |=> !cpu_stall)
      else $error("stall without access");
   AST_NO_ARM: assert property (ctl_wr && io_wdata[`BEE_CTL_WRITE] && !arm_act && !busy |=> !busy)
      else $error("write started without arm");
   AST_LOCKED: assert property (ctl_wr && upper_locked && !busy |=> !busy)
      else $error("write started into locked area");
   AST_UPPER_OPEN: assert property (ctl_wr && io_wdata[`BEE_CTL_WRITE] && arm_act && !busy
      && !upper_area_lock_fuse && !flash_selfprog_active && (s_r.ptr > `BEE_LOWER_LAST)
      && (io_wdata[`BEE_CTL_ACT_HI:`BEE_CTL_ACT_LO] != 2'(bee_pkg::BEE_ACT_RESERVED)) |=> busy)
      else $error("unlocked upper write not started");
   AST_RSVD_REFUSED: assert property (ctl_wr && !busy
      && (io_wdata[`BEE_CTL_ACT_HI:`BEE_CTL_ACT_LO] == 2'(bee_pkg::BEE_ACT_RESERVED)) |=> !busy)
      else $error("reserved action started programming");
   AST_ACT_READBACK: assert property (io_rd && (io_addr == `BEE_REG_CTRL)
      |=> io_rdata[`BEE_CTL_ACT_HI:`BEE_CTL_ACT_LO] == $past(action))
      else $error("action field read back wrong");
   AST_START_BUSY: assert property (start |=> busy)
      else $error("busy not set on start");
   AST_DONE_IDLE: assert property (eng_done |-> !busy)
      else $error("completion pulse while busy");
   AST_PTR_FROZEN: assert property (busy && io_wr |=> $stable(s_r.ptr))
      else $error("pointer changed while busy");
   AST_RD_BLOCKED: assert property (busy && ctl_wr |=> s_r.value == $past(s_r.value))
      else $error("value changed by read while busy");
   AST_RD_NO_STALL: assert property (busy && ctl_wr && !cpu_stall |=> !cpu_stall)
      else $error("stall from refused request");
   AST_PTR_LO_WR: assert property (io_wr && (io_addr == `BEE_REG_PTR_LO) && !busy
      |=> s_r.ptr[7:0] == $past(io_wdata))
      else $error("pointer low write lost");
   AST_PTR_HI_READ: assert property (io_rd && (io_addr == `BEE_REG_PTR_HI) |=> io_rdata[7:1] == 7'h00)
      else $error("reserved pointer bits not zero");
   AST_CTL_READ_ZERO: assert property (io_rd && (io_addr == `BEE_REG_CTRL)
      |=> (io_rdata[7:6] == 2'h0) && !io_rdata[`BEE_CTL_READ])
      else $error("control read strobe or reserved bits not zero");
   AST_ACT_HOLD: assert property (busy && ctl_wr |=> action == $past(action))
      else $error("action changed while busy");
   AST_RD_VALUE: assert property (read_go |=> s_r.value == $past(array_rd))
      else $error("read byte not in value register");
   AST_RANGE_READ: assert property (read_go && (s_r.ptr > `BEE_NVM_LAST) |=> s_r.value == `BEE_ERASED_BYTE)
      else $error("unmapped read not erased value");
   AST_VALUE_WR: assert property (io_wr && (io_addr == `BEE_REG_VALUE) |=> s_r.value == $past(io_wdata))
      else $error("value write lost");
   AST_START_LATCH: assert property (start
      |=> (done_addr == $past(s_r.ptr)) && (done_data == $past(s_r.value)))
      else $error("pointer or value not latched at start");
   AST_IRQ_BUSY: assert property ($past(busy) |-> !ready_irq)
      else $error("ready interrupt while busy");
   AST_IRQ_READY: assert property (!busy && s_r.irq_en && cpu_global_irq_en && !io_wr |=> ready_irq)
      else $error("ready interrupt missing");
   AST_IRQ_GLOBAL: assert property (!cpu_global_irq_en |=> !ready_irq)
      else $error("ready interrupt with global flag clear");
   AST_IRQ_EN_OFF: assert property (!s_r.irq_en && !ctl_wr |=> !ready_irq)
      else $error("ready interrupt while disabled");

   COV_WRITE: cover property (start ##[1:1000] eng_done);
   COV_READ: cover property (read_go ##4 !cpu_stall);
   COV_IRQ: cover property (busy ##1 !busy ##1 ready_irq);
   COV_LOCKED: cover property (ctl_wr && io_wdata[`BEE_CTL_WRITE] && arm_act && upper_locked);
   COV_RESERVED: cover property (ctl_wr && io_wdata[`BEE_CTL_WRITE] && arm_act
      && (io_wdata[`BEE_CTL_ACT_HI:`BEE_CTL_ACT_LO] == 2'(bee_pkg::BEE_ACT_RESERVED)));

endmodule // bee_access_ctrl

`default_nettype wire

// ==== bee_rc_osc_model.sv ====
`timescale 1ns/1ps
`default_nettype none

// ==========================================
// Calibrated oscillator stand-in, runs free of the CPU reset
module bee_rc_osc_model (
   // Clock and power-on reset
   input wire logic sys_clk,
   input wire logic por_n,
   // Tick spacing in sys_clk cycles, at least 2
   input wire logic [4:0] period,
   // Tick output
   output logic rc_osc_tick
);
   logic [4:0] cnt_r;

   always_ff @(posedge sys_clk or negedge por_n) begin
      if (!por_n) begin
         cnt_r <= 5'h00;
         rc_osc_tick <= 1'b0;
      end else if (cnt_r >= period - 5'h01) begin
         cnt_r <= 5'h00;
         rc_osc_tick <= 1'b1;
      end else begin
         cnt_r <= cnt_r + 5'h01;
         rc_osc_tick <= 1'b0;
      end
   end
endmodule // bee_rc_osc_model

`default_nettype wire

// ==== test_bee_access_ctrl.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "bee_consts.svh"

module test_bee_access_ctrl;
   localparam logic [1:0] CT = `BEE_REG_CTRL;
   localparam logic [1:0] VA = `BEE_REG_VALUE;
   localparam logic [1:0] PL = `BEE_REG_PTR_LO;
   localparam logic [1:0] PH = `BEE_REG_PTR_HI;
   logic sys_clk, rst_n, por_n, io_wr, io_rd, cpu_global_irq_en, upper_area_lock_fuse, flash_selfprog_active;
   logic [1:0] io_addr;
   logic [7:0] io_wdata, d;
   logic [7:0] io_rdata;
   logic cpu_stall, ready_irq, rc_osc_tick;
   logic [4:0] period;
   int mismatches, total_checks, ticks;

   // ==========================================
   // Design and oscillator
   bee_access_ctrl #(.EW_TICKS(8), .HALF_TICKS(4)) i_bee_access_ctrl (.sys_clk(sys_clk), .rst_n(rst_n),
      .por_n(por_n), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata),
      .cpu_stall(cpu_stall), .cpu_global_irq_en(cpu_global_irq_en), .ready_irq(ready_irq),
      .upper_area_lock_fuse(upper_area_lock_fuse), .flash_selfprog_active(flash_selfprog_active),
      .rc_osc_tick(rc_osc_tick));
   bee_rc_osc_model i_bee_rc_osc_model (.sys_clk(sys_clk), .por_n(por_n), .period(period),
      .rc_osc_tick(rc_osc_tick));

   always @(posedge sys_clk) begin
      if (rc_osc_tick === 1'b1)
         ticks++;
   end

   // ==========================================
   // Bus cycles and checks
   task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      total_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic wr(input logic [1:0] a, input logic [7:0] v);
      @(posedge sys_clk);
      #1;
      io_addr = a;
      io_wdata = v;
      io_wr = 1'b1;
      @(posedge sys_clk);
      #1;
      io_wr = 1'b0;
   endtask

   // Data held until the next read, so one extra edge is safe
   task automatic rd(input logic [1:0] a);
      @(posedge sys_clk);
      #1;
      io_addr = a;
      io_rd = 1'b1;
      @(posedge sys_clk);
      #1;
      io_rd = 1'b0;
      @(posedge sys_clk);
      #1;
      d = io_rdata;
   endtask

   task automatic stalls(input logic [7:0] exp);
      int n;
      n = 0;
      repeat (8) begin
         if (cpu_stall === 1'b1)
            n++;
         @(posedge sys_clk);
         #1;
      end
      chk("stall cycles", 8'(n), exp);
   endtask

   task automatic wait_idle();
      int i;
      i = 0;
      do begin
         rd(CT);
         i++;
      end while (d[1] !== 1'b0 && i < 100);
      chk("busy cleared", {7'h00, d[1]}, 8'h00);
   endtask

   task automatic setp(input logic [8:0] a);
      wr(PH, {7'h00, a[8]});
      wr(PL, a[7:0]);
   endtask

   task automatic prog(input logic [8:0] a, input logic [1:0] act, input logic [7:0] v, input logic go);
      int t0, n;
      setp(a);
      wr(VA, v);
      wr(CT, {2'b00, act, 4'h4});
      t0 = ticks;
      wr(CT, {2'b00, act, 4'h2});
      stalls(go ? 8'h02 : 8'h00);
      wait_idle();
      n = (act == 2'b00) ? 8 : 4;
      if (go)
         chk("prog ticks", 8'((ticks - t0 == n) || (ticks - t0 == n + 1)), 8'h01);
   endtask

   task automatic readb(input logic [8:0] a, input logic [7:0] exp);
      setp(a);
      wr(CT, 8'h01);
      stalls(8'h04);
      rd(VA);
      chk("stored byte", d, exp);
      rd(CT);
      chk("read strobe back", d & 8'h01, 8'h00);
   endtask

   task automatic rst_pulse();
      @(posedge sys_clk);
      #1;
      rst_n = 1'b0;
      @(posedge sys_clk);
      #1;
      rst_n = 1'b1;
   endtask

   // ==========================================
   // Scenarios
   task automatic t_reset();
      rd(CT);
      chk("ctrl after reset", d, 8'h00);
      wr(PH, 8'hFF);
      rd(PH);
      chk("pointer high", d, 8'h01);
      $display("test reset done");
   endtask

   task automatic t_modes();
      logic [7:0] dat[4] = '{8'h5A, 8'h00, 8'h3C, 8'h00};
      logic [7:0] exp[4] = '{8'h5A, 8'hFF, 8'h3C, 8'h3C};
      prog(9'h000, 2'b00, 8'hC3, 1'b1);
      readb(9'h000, 8'hC3);
      for (int i = 0; i < 4; i++) begin
         prog(`BEE_NVM_LAST, 2'(i), dat[i], i < 3);
         readb(`BEE_NVM_LAST, exp[i]);
      end
      $display("test modes done");
   endtask

   task automatic t_arm();
      wr(CT, 8'h02);
      stalls(8'h00);
      rd(CT);
      chk("ctrl no arm", d, 8'h00);
      wr(CT, 8'h04);
      rd(CT);
      chk("armed", d, 8'h04);
      // Strobe lands on the fifth edge after arming, just past the window
      wr(CT, 8'h02);
      stalls(8'h00);
      rd(CT);
      chk("arm expired", d, 8'h00);
      $display("test arm done");
   endtask

   // Slow ticks so that the checks up to action kept fit inside one busy span
   task automatic t_busy();
      period = 5'd20;
      setp(9'h010);
      wr(VA, 8'h77);
      wr(CT, 8'h14);
      wr(CT, 8'h12);
      stalls(8'h02);
      wr(PL, 8'h20);
      wr(CT, 8'h21);
      stalls(8'h00);
      rd(CT);
      chk("ctrl busy", d, 8'h12);
      rd(PL);
      chk("pointer held", d, 8'h10);
      rd(VA);
      chk("value held", d, 8'h77);
      rst_pulse();
      rd(CT);
      chk("action kept", d, 8'h12);
      wait_idle();
      rd(CT);
      chk("action after", d, 8'h10);
      rst_pulse();
      rd(CT);
      chk("action cleared", d, 8'h00);
      period = 5'd8;
      readb(9'h010, 8'hFF);
      $display("test busy done");
   endtask

   task automatic t_lock();
      prog(9'h100, 2'b00, 8'h22, 1'b1);
      readb(9'h100, 8'h22);
      upper_area_lock_fuse = 1'b1;
      prog(9'h100, 2'b00, 8'h11, 1'b0);
      readb(9'h100, 8'h22);
      prog(`BEE_LOWER_LAST, 2'b00, 8'h33, 1'b1);
      readb(`BEE_LOWER_LAST, 8'h33);
      upper_area_lock_fuse = 1'b0;
      flash_selfprog_active = 1'b1;
      prog(9'h100, 2'b00, 8'h44, 1'b0);
      readb(9'h100, 8'h22);
      flash_selfprog_active = 1'b0;
      prog(9'h100, 2'b00, 8'h44, 1'b1);
      readb(9'h100, 8'h44);
      $display("test lock done");
   endtask

   task automatic t_irq();
      cpu_global_irq_en = 1'b1;
      wr(CT, 8'h08);
      repeat (2) @(posedge sys_clk);
      #1;
      chk("irq idle", {7'h00, ready_irq}, 8'h01);
      cpu_global_irq_en = 1'b0;
      wr(CT, 8'h0C);
      wr(CT, 8'h0A);
      cpu_global_irq_en = 1'b1;
      repeat (3) @(posedge sys_clk);
      #1;
      chk("irq busy", {7'h00, ready_irq}, 8'h00);
      wait_idle();
      repeat (2) @(posedge sys_clk);
      #1;
      chk("irq ready", {7'h00, ready_irq}, 8'h01);
      cpu_global_irq_en = 1'b0;
      repeat (2) @(posedge sys_clk);
      #1;
      chk("irq global off", {7'h00, ready_irq}, 8'h00);
      $display("test irq done");
   endtask

   task automatic conclude();
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   // ==========================================
   // Clock, reset, sequence and watchdog
   initial begin
      sys_clk = 1'b0;
      forever #25 sys_clk = ~sys_clk;
   end

   initial begin
      {rst_n, por_n, io_wr, io_rd, cpu_global_irq_en, upper_area_lock_fuse, flash_selfprog_active} = '0;
      io_addr = 2'h0;
      io_wdata = 8'h00;
      period = 5'd8;
      repeat (6) @(posedge sys_clk);
      #1;
      rst_n = 1'b1;
      por_n = 1'b1;
      t_reset();
      t_modes();
      t_arm();
      t_busy();
      t_lock();
      t_irq();
      conclude();
   end

   initial begin
      #(50 * 20000);
      mismatches++;
      conclude();
   end
endmodule // test_bee_access_ctrl

`default_nettype wire
